// File: hdl/clock_select_reset_watchdog.sv
// Clock source select, reset sequencer, clock monitor reset and watchdog with AHB-Lite access.
// Contract
// - Clock select writes take effect only while the lock flag is clear.
// - Special mode lets every clock select bit except bits 5:4, which the mask clears, be written while the lock flag is clear.
// - Normal mode lets loop, stop, run-in-stop and periodic select bits be written.
// - Normal mode: watchdog source writable until watchdog control written, once more after clearing.
// - Loop select picks loop clock, else crystal; bus runs at source divided by two.
// - Loop select clears only while the oscillator is up.
// - Loop select forced high when oscillator down or full stop entered.
// - Keep-in-stop bit chooses pseudo stop, else oscillator off in stop.
// - Internal reset held 768 cycles, longer while external pin stays low.
// - Oscillator enabled and failing raises a clock monitor reset.
// - Full stop disables oscillator and clock monitor.
// - Watchdog counts internal reference or crystal ticks per its source select.
// - In stop the watchdog runs only with keep, source and run bits all set.
// - Three-bit field selects seven time-out periods or off.
// - Writing 0x55 then 0xAA restarts the time-out period.
// - Time-out without service raises a watchdog reset.
// - While the watchdog is on, any service value other than 0x55 or 0xAA raises a watchdog reset.
`timescale 1ns/10ps
module clock_select_reset_watchdog
  import clock_reset_pkg::*;
#(
  parameter int WD_BASE_BITS = 14
) (
  input wire logic CORE_CLK, // Core clock, 25 MHz.
  input wire logic RST_N, // Synchronous reset, active low.
  input wire logic HSEL, // AHB slave select.
  input wire logic [31:0] HADDR, // AHB address.
  input wire logic [1:0] HTRANS, // AHB transfer type.
  input wire logic HWRITE, // AHB write.
  input wire logic [2:0] HSIZE, // AHB size, word only.
  input wire logic [31:0] HWDATA, // AHB write data.
  input wire logic HREADY, // AHB bus ready.
  output logic [31:0] HRDATA, // AHB read data.
  output logic HREADYOUT, // AHB slave ready.
  output logic HRESP, // AHB response, always OKAY.
  input wire logic SPECIAL_MODE, // High in special operating modes.
  input wire logic STOP_MODE, // High while the device is in stop mode.
  input wire logic OSC_ENABLE, // Oscillator enable setting.
  input wire logic OSC_UP, // Oscillator up flag.
  input wire logic OSC_FAIL, // Oscillation lost or below failure threshold.
  input wire logic OSC_TICK, // One pulse per crystal clock cycle.
  input wire logic IRC_TICK, // One pulse per internal reference clock cycle.
  input wire logic EXT_RESET_N, // External reset pin, active low.
  output logic [7:0] CLOCK_SELECT, // Clock select register contents.
  output logic SYS_FROM_LOOP, // High when system clocks come from the loop clock.
  output logic BUS_TICK, // One pulse per bus clock cycle.
  output logic OSC_RUN, // Oscillator allowed to run.
  output logic MONITOR_ON, // Clock monitor active.
  output logic INTERNAL_RESET_N // Internal reset, active low.
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0] addr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [31:0] hrdata_reg;
  logic hready_reg;
  logic [7:0] clksel_reg;
  logic [7:0] clksel_next;
  logic lock_reg;
  logic [2:0] wdctl_reg;
  logic wd_written_reg;
  logic wd_resel_ok_reg;
  logic armed_reg;
  logic stop_d_reg;
  logic mon_cause_reg;
  logic wd_cause_reg;
  logic ext_cause_reg;
  reset_state_type rs_reg;
  reset_state_type rs_next;
  logic [9:0] seq_count_reg;
  logic int_rst_n_reg;
  logic div_reg;
  logic bus_tick_reg;
  logic osc_run_reg;
  logic monitor_on_reg;
  logic taken;
  logic [7:0] wbyte;
  logic ctl_rst;
  logic wr_clk;
  logic wr_write_lock_flag;
  logic wr_wdctl;
  logic wr_svc;
  logic wr_status;
  logic full_stop;
  logic stop_entry;
  logic wd_enabled;
  logic bad_service;
  logic wd_restart;
  logic wd_run;
  logic wd_tick;
  logic wd_timeout;
  logic mon_fail;
  logic wd_fire;
  logic reset_request;
  logic src_tick;

  assign taken = HSEL && HREADY && HTRANS[1];
  assign wbyte = HWDATA[7:0];
  assign ctl_rst = !RST_N || !int_rst_n_reg;
  assign wr_clk = wr_pend_reg && addr_reg == OFF_CLOCK_SELECT;
  assign wr_write_lock_flag = wr_pend_reg && addr_reg == OFF_PROTECTION;
  assign wr_wdctl = wr_pend_reg && addr_reg == OFF_WD_CONTROL;
  assign wr_svc = wr_pend_reg && addr_reg == OFF_WD_SERVICE;
  assign wr_status = wr_pend_reg && addr_reg == OFF_STATUS;
  assign full_stop = STOP_MODE && !clksel_reg[KEEP_IN_STOP_BIT];
  assign stop_entry = STOP_MODE && !stop_d_reg;
  assign wd_enabled = wdctl_reg != WD_RATE_OFF;
  assign bad_service = wr_svc && wd_enabled && wbyte != SERVICE_FIRST
    && wbyte != SERVICE_SECOND;
  assign wd_restart = wr_svc && wd_enabled && armed_reg && wbyte == SERVICE_SECOND;
  assign wd_run = !STOP_MODE || (clksel_reg[KEEP_IN_STOP_BIT] && clksel_reg[WD_SEL_BIT]
    && clksel_reg[WD_RUN_BIT]);
  assign wd_tick = wd_run && (clksel_reg[WD_SEL_BIT] ? OSC_TICK : IRC_TICK);
  assign mon_fail = OSC_ENABLE && !full_stop && OSC_FAIL && int_rst_n_reg;
  assign wd_fire = wd_timeout || bad_service;
  assign reset_request = mon_fail || wd_fire || !EXT_RESET_N;
  assign src_tick = clksel_reg[LOOP_SEL_BIT] ? 1'b1 : OSC_TICK;

  assign HRDATA = hrdata_reg;
  assign HREADYOUT = hready_reg;
  assign HRESP = HRESP_OKAY;
  assign CLOCK_SELECT = clksel_reg;
  assign SYS_FROM_LOOP = clksel_reg[LOOP_SEL_BIT];
  assign BUS_TICK = bus_tick_reg;
  assign OSC_RUN = osc_run_reg;
  assign MONITOR_ON = monitor_on_reg;
  assign INTERNAL_RESET_N = int_rst_n_reg;

  // ==========================================================================
  // AHB-Lite slave
  // ==========================================================================
  // Reads take one wait state so that a write in the preceding data phase is seen.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      addr_reg <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hready_reg <= 1'b1;
      hrdata_reg <= 32'h0;
    end else begin
      wr_pend_reg <= taken && HWRITE;
      if (taken) begin
        addr_reg <= HADDR[7:0];
      end
      if (taken && !HWRITE) begin
        rd_pend_reg <= 1'b1;
        hready_reg <= 1'b0;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        hready_reg <= 1'b1;
        case (addr_reg)
          OFF_CLOCK_SELECT: hrdata_reg <= {24'h0, clksel_reg};
          OFF_PROTECTION: hrdata_reg <= {31'h0, lock_reg};
          OFF_WD_CONTROL: hrdata_reg <= {29'h0, wdctl_reg};
          OFF_STATUS: hrdata_reg <= {26'h0, wd_written_reg, ext_cause_reg, wd_cause_reg,
            mon_cause_reg, full_stop, OSC_UP};
          default: hrdata_reg <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Clock select register
  // ==========================================================================
  always_comb begin
    clksel_next = clksel_reg;
    if (wr_clk && !lock_reg) begin
      if (SPECIAL_MODE) begin
        clksel_next = wbyte & CLOCK_SELECT_MASK;
      end else begin
        clksel_next[LOOP_SEL_BIT] = wbyte[LOOP_SEL_BIT];
        clksel_next[KEEP_IN_STOP_BIT] = wbyte[KEEP_IN_STOP_BIT];
        clksel_next[PERIODIC_RUN_BIT] = wbyte[PERIODIC_RUN_BIT];
        clksel_next[WD_RUN_BIT] = wbyte[WD_RUN_BIT];
        clksel_next[PERIODIC_SEL_BIT] = wbyte[PERIODIC_SEL_BIT];
        if (!wd_written_reg || (wd_resel_ok_reg && wbyte[WD_SEL_BIT])) begin
          clksel_next[WD_SEL_BIT] = wbyte[WD_SEL_BIT];
        end
      end
      if (!OSC_UP) begin
        clksel_next[LOOP_SEL_BIT] = 1'b1;
      end
    end
    if (!OSC_UP) begin
      clksel_next[LOOP_SEL_BIT] = 1'b1;
      clksel_next[WD_SEL_BIT] = 1'b0;
    end
    if (stop_entry && !clksel_reg[KEEP_IN_STOP_BIT]) begin
      clksel_next[LOOP_SEL_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst) begin
      clksel_reg <= CLOCK_SELECT_RESET;
    end else begin
      clksel_reg <= clksel_next;
    end
  end

  // The extra watchdog source write is granted after a hardware clear; setting wins.
  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst) begin
      wd_resel_ok_reg <= 1'b0;
    end else if (clksel_reg[WD_SEL_BIT] && !OSC_UP) begin
      wd_resel_ok_reg <= 1'b1;
    end else if (wr_clk && !lock_reg && !SPECIAL_MODE && wd_written_reg
      && wbyte[WD_SEL_BIT]) begin
      wd_resel_ok_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Protection and watchdog control
  // ==========================================================================
  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst) begin
      lock_reg <= 1'b0;
    end else if (wr_write_lock_flag) begin
      lock_reg <= wbyte[LOCK_BIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst) begin
      wdctl_reg <= WD_RATE_RESET;
      wd_written_reg <= 1'b0;
    end else if (wr_wdctl && (SPECIAL_MODE || !wd_written_reg)) begin
      wdctl_reg <= wbyte[2:0];
      wd_written_reg <= !SPECIAL_MODE;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (ctl_rst) begin
      armed_reg <= 1'b0;
    end else if (wr_svc) begin
      armed_reg <= wbyte == SERVICE_FIRST;
    end
  end

  watchdog_counter #(
    .BASE_BITS(WD_BASE_BITS)
  ) u_watchdog (
    .clk(CORE_CLK),
    .rst_n(!ctl_rst),
    .tick(wd_tick),
    .restart(wd_restart),
    .rate(wdctl_reg),
    .timeout_reg(wd_timeout)
  );

  // ==========================================================================
  // Reset sequencer
  // ==========================================================================
  always_comb begin
    rs_next = rs_reg;
    case (rs_reg)
      RS_RUN: begin
        if (reset_request) begin
          rs_next = RS_HOLD;
        end
      end
      RS_HOLD: begin
        if (seq_count_reg == RESET_SEQ_LAST) begin
          rs_next = EXT_RESET_N ? RS_RUN : RS_PIN;
        end
      end
      RS_PIN: begin
        if (EXT_RESET_N) begin
          rs_next = RS_RUN;
        end
      end
      default: rs_next = RS_HOLD;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rs_reg <= RS_HOLD;
      seq_count_reg <= 10'h000;
      int_rst_n_reg <= 1'b0;
    end else begin
      rs_reg <= rs_next;
      int_rst_n_reg <= rs_next == RS_RUN;
      if (rs_reg == RS_HOLD && rs_next == RS_HOLD) begin
        seq_count_reg <= seq_count_reg + 10'h001;
      end else begin
        seq_count_reg <= 10'h000;
      end
    end
  end

  // Reset causes survive the internal reset; a new cause wins over a clear.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      mon_cause_reg <= 1'b0;
      wd_cause_reg <= 1'b0;
      ext_cause_reg <= 1'b0;
    end else begin
      mon_cause_reg <= mon_fail || (mon_cause_reg && !(wr_status && wbyte[ST_MON_CAUSE_BIT]));
      wd_cause_reg <= wd_fire || (wd_cause_reg && !(wr_status && wbyte[ST_WD_CAUSE_BIT]));
      ext_cause_reg <= (!EXT_RESET_N && rs_reg == RS_RUN)
        || (ext_cause_reg && !(wr_status && wbyte[ST_EXT_CAUSE_BIT]));
    end
  end

  // ==========================================================================
  // Stop handling, oscillator and bus clock
  // ==========================================================================
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      stop_d_reg <= 1'b0;
      osc_run_reg <= 1'b0;
      monitor_on_reg <= 1'b0;
    end else begin
      stop_d_reg <= STOP_MODE;
      osc_run_reg <= OSC_ENABLE && !full_stop;
      monitor_on_reg <= OSC_ENABLE && !full_stop;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      div_reg <= 1'b0;
      bus_tick_reg <= 1'b0;
    end else begin
      bus_tick_reg <= src_tick && div_reg == BUS_DIV_LAST;
      if (src_tick) begin
        div_reg <= div_reg == BUS_DIV_LAST ? 1'b0 : div_reg + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_lock_blocks;
    wr_clk && lock_reg && OSC_UP && !STOP_MODE && int_rst_n_reg |=> $stable(clksel_reg);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked write changed clock select");

  property p_special_write;
    wr_clk && !lock_reg && SPECIAL_MODE && OSC_UP && !STOP_MODE && int_rst_n_reg
      |=> clksel_reg == ($past(wbyte) & CLOCK_SELECT_MASK);
  endproperty
  a_special_write: assert property (p_special_write) else $error("special write not taken");

  property p_wd_sel_once;
    wr_clk && !SPECIAL_MODE && wd_written_reg && !wd_resel_ok_reg && OSC_UP && int_rst_n_reg
      |=> clksel_reg[WD_SEL_BIT] == $past(clksel_reg[WD_SEL_BIT]);
  endproperty
  a_wd_sel_once: assert property (p_wd_sel_once) else $error("watchdog source changed");

  property p_loop_forced;
    !OSC_UP |=> clksel_reg[LOOP_SEL_BIT];
  endproperty
  a_loop_forced: assert property (p_loop_forced) else $error("loop select not forced");

  property p_full_stop_osc;
    full_stop ##1 full_stop |-> !osc_run_reg && !monitor_on_reg;
  endproperty
  a_full_stop_osc: assert property (p_full_stop_osc) else $error("oscillator on in full stop");

  property p_reset_hold;
    rs_reg == RS_RUN && reset_request |=> !int_rst_n_reg [*8];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("internal reset too short");

  property p_reset_release;
    rs_reg == RS_HOLD && seq_count_reg == RESET_SEQ_LAST && EXT_RESET_N |=> int_rst_n_reg;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset not released");

  property p_pin_extends;
    rs_reg == RS_HOLD && seq_count_reg == RESET_SEQ_LAST && !EXT_RESET_N
      |=> !int_rst_n_reg && rs_reg == RS_PIN;
  endproperty
  a_pin_extends: assert property (p_pin_extends) else $error("pin low did not extend");

  property p_monitor;
    mon_fail |=> mon_cause_reg && !int_rst_n_reg;
  endproperty
  a_monitor: assert property (p_monitor) else $error("clock monitor reset missing");

  property p_stop_halt;
    STOP_MODE && !(clksel_reg[KEEP_IN_STOP_BIT] && clksel_reg[WD_SEL_BIT]
      && clksel_reg[WD_RUN_BIT]) |-> !wd_tick;
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("watchdog ran in stop");

  property p_bad_service;
    bad_service |=> wd_cause_reg && !int_rst_n_reg;
  endproperty
  a_bad_service: assert property (p_bad_service) else $error("bad service not punished");

  property p_timeout;
    wd_timeout |=> wd_cause_reg ##1 !int_rst_n_reg;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out reset missing");

  c_service: cover property (wr_svc && wbyte == SERVICE_FIRST ##[1:20] wd_restart);
  c_timeout: cover property (wd_timeout);
  c_monitor: cover property (mon_fail);
  c_pin_hold: cover property (rs_reg == RS_PIN);

endmodule : clock_select_reset_watchdog

// File: hdl/clock_reset_pkg.sv
// Shared constants for the clock select, reset sequencer and watchdog block.
package clock_reset_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CORE_CLK_PERIOD_NS = 40;
  localparam int RESET_SEQ_CYCLES = 768;
  localparam logic [9:0] RESET_SEQ_LAST = 10'(RESET_SEQ_CYCLES - 1);
  localparam int BUS_DIV = 2;
  localparam logic BUS_DIV_LAST = 1'(BUS_DIV - 1);

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFF_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] OFF_PROTECTION = 8'h04;
  localparam logic [7:0] OFF_WD_CONTROL = 8'h08;
  localparam logic [7:0] OFF_WD_SERVICE = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // ==========================================================================
  // Clock select fields and reset value
  // ==========================================================================
  localparam int LOOP_SEL_BIT = 7;
  localparam int KEEP_IN_STOP_BIT = 6;
  localparam int PERIODIC_RUN_BIT = 3;
  localparam int WD_RUN_BIT = 2;
  localparam int PERIODIC_SEL_BIT = 1;
  localparam int WD_SEL_BIT = 0;
  localparam logic [7:0] CLOCK_SELECT_RESET = 8'h80;
  localparam logic [7:0] CLOCK_SELECT_MASK = 8'hCF;

  // ==========================================================================
  // Protection, watchdog and status fields
  // ==========================================================================
  localparam int LOCK_BIT = 0;
  localparam logic [2:0] WD_RATE_OFF = 3'h0;
  localparam logic [2:0] WD_RATE_RESET = 3'h0;
  localparam logic [7:0] SERVICE_FIRST = 8'h55;
  localparam logic [7:0] SERVICE_SECOND = 8'hAA;
  localparam int ST_OSC_UP_BIT = 0;
  localparam int ST_FULL_STOP_BIT = 1;
  localparam int ST_MON_CAUSE_BIT = 2;
  localparam int ST_WD_CAUSE_BIT = 3;
  localparam int ST_EXT_CAUSE_BIT = 4;
  localparam int ST_WD_WRITTEN_BIT = 5;

  // ==========================================================================
  // Bus constants
  // ==========================================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [2:0] {
    RS_RUN = 3'h1,
    RS_HOLD = 3'h2,
    RS_PIN = 3'h4
  } reset_state_type;

endpackage : clock_reset_pkg

// File: hdl/watchdog_counter.sv
// Free-running watchdog counter with selectable time-out period.
`timescale 1ns/10ps
module watchdog_counter
  import clock_reset_pkg::*;
#(
  parameter int BASE_BITS = 14
) (
  input wire logic clk, // Core clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic tick, // One count step of the selected watchdog source.
  input wire logic restart, // Restart the time-out period.
  input wire logic [2:0] rate, // Time-out period select.
  output logic timeout_reg // One-cycle pulse on time-out.
);

  logic [31:0] count_reg;

  // Period in source ticks for each non-off rate code.
  function automatic logic [31:0] wd_limit(input logic [2:0] r);
    logic [4:0] step;
    step = 5'h0;
    case (r)
      3'h1: step = 5'h0;
      3'h2: step = 5'h2;
      3'h3: step = 5'h4;
      3'h4: step = 5'h6;
      3'h5: step = 5'h8;
      3'h6: step = 5'h9;
      3'h7: step = 5'hA;
      default: step = 5'h0;
    endcase
    return 32'h1 << (5'(BASE_BITS) + step);
  endfunction : wd_limit

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_ff @(posedge clk) begin
    timeout_reg <= 1'b0;
    if (!rst_n || restart || rate == WD_RATE_OFF) begin
      count_reg <= 32'h0;
    end else if (tick) begin
      if (count_reg >= wd_limit(rate) - 32'h1) begin
        count_reg <= 32'h0;
        timeout_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 32'h1;
      end
    end
  end

endmodule : watchdog_counter

// File: sim/tb_top.sv
// Self-checking bench for the clock select, reset sequencer and watchdog block.
`timescale 1ns/10ps
module tb_top
  import clock_reset_pkg::*;
;
  // ==========================================================================
  // Stimulus, design and sampled copies
  // ==========================================================================
  logic CORE_CLK, HREADYOUT, OSC_RUN, MONITOR_ON, SYS_FROM_LOOP, INTERNAL_RESET_N, BUS_TICK;
  logic OSC_ENABLE = 1'b1, OSC_TICK = 1'b0;
  logic RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, SPECIAL_MODE = 1'b0, STOP_MODE = 1'b0;
  logic OSC_UP = 1'b1, OSC_FAIL = 1'b0, IRC_TICK = 1'b0, EXT_RESET_N = 1'b1;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd_s, rdata;
  logic rdy_s, irst_s, run_s, mon_s, loop_s, bus_s;
  int error_cnt = 0, checks = 0, cnt, btk = 0;
  int steps[7] = '{0, 2, 4, 6, 8, 9, 10};

  clock_select_reset_watchdog #(.WD_BASE_BITS(2)) DUT (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(), .SPECIAL_MODE(SPECIAL_MODE), .STOP_MODE(STOP_MODE),
    .OSC_ENABLE(OSC_ENABLE), .OSC_UP(OSC_UP), .OSC_FAIL(OSC_FAIL), .OSC_TICK(OSC_TICK),
    .IRC_TICK(IRC_TICK), .EXT_RESET_N(EXT_RESET_N), .CLOCK_SELECT(),
    .SYS_FROM_LOOP(SYS_FROM_LOOP), .BUS_TICK(BUS_TICK), .OSC_RUN(OSC_RUN), .MONITOR_ON(MONITOR_ON),
    .INTERNAL_RESET_N(INTERNAL_RESET_N)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  // Outputs are copied mid-cycle so that each rising edge sees the settled values.
  always @(negedge CORE_CLK) begin
    rdy_s <= HREADYOUT;
    rd_s <= HRDATA;
    irst_s <= INTERNAL_RESET_N;
    run_s <= OSC_RUN;
    mon_s <= MONITOR_ON;
    loop_s <= SYS_FROM_LOOP;
    bus_s <= BUS_TICK;
  end

  // Running count of bus clock pulses, read as differences by the sequence.
  always @(posedge CORE_CLK) btk <= btk + int'(bus_s);

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic give_up();
    error_cnt++;
    stop_test();
  endtask : give_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CORE_CLK); while (rdy_s !== 1'b1 && ++n < 40);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CORE_CLK); while (rdy_s !== 1'b1 && ++n < 40);
    rdata = rd_s;
    if (n >= 40) give_up();
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, m = 32'hFF);
    bus(1'b0, a, 32'h0);
    check(rdata & m, e);
  endtask : rdchk

  task automatic wait_rst(input logic lvl, input int lim);
    cnt = 0;
    while (irst_s !== lvl && cnt++ < lim) @(posedge CORE_CLK);
    if (cnt > lim) give_up();
  endtask : wait_rst

  task automatic ticks(input int n, input logic osc = 1'b0);
    repeat (n) begin
      IRC_TICK <= !osc;
      OSC_TICK <= osc;
      @(posedge CORE_CLK);
      IRC_TICK <= 1'b0;
      OSC_TICK <= 1'b0;
      @(posedge CORE_CLK);
    end
  endtask : ticks

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    wait_rst(1'b1, 1000);
    check(32'(cnt >= 765 && cnt <= 772), 32'h1);
    rdchk(OFF_CLOCK_SELECT, 32'h80);
    cnt = btk;
    repeat (20) @(posedge CORE_CLK);
    check(32'(btk - cnt), 32'hA);
    bus(1'b1, OFF_PROTECTION, 32'h1);
    bus(1'b1, OFF_CLOCK_SELECT, 32'hCE);
    rdchk(OFF_CLOCK_SELECT, 32'h80);
    bus(1'b1, OFF_PROTECTION, 32'h0);
    bus(1'b1, OFF_CLOCK_SELECT, 32'h7E);
    rdchk(OFF_CLOCK_SELECT, 32'h4E);
    check(32'(loop_s), 32'h0);
    OSC_UP <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    rdchk(OFF_CLOCK_SELECT, 32'hCE);
    check(32'(loop_s), 32'h1);
    bus(1'b1, OFF_CLOCK_SELECT, 32'h4E);
    rdchk(OFF_CLOCK_SELECT, 32'hCE);
    OSC_UP <= 1'b1;
    bus(1'b1, OFF_CLOCK_SELECT, 32'h01);
    rdchk(OFF_CLOCK_SELECT, 32'h01);
    check(32'(loop_s), 32'h0);
    cnt = btk;
    ticks(10, 1'b1);
    repeat (2) @(posedge CORE_CLK);
    check(32'(btk - cnt), 32'h5);
    $display("Register test done");
    bus(1'b1, OFF_CLOCK_SELECT, 32'h00);
    STOP_MODE <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    OSC_FAIL <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    check(32'({run_s, mon_s, irst_s}), 32'h1);
    rdchk(OFF_CLOCK_SELECT, 32'h80);
    STOP_MODE <= 1'b0;
    OSC_ENABLE <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    check(32'({run_s, irst_s}), 32'h1);
    OSC_ENABLE <= 1'b1;
    wait_rst(1'b0, 5);
    OSC_FAIL <= 1'b0;
    wait_rst(1'b1, 1000);
    check(32'(cnt >= 765 && cnt <= 772), 32'h1);
    rdchk(OFF_STATUS, 32'h04, 32'h04);
    $display("Stop and monitor test done");
    bus(1'b1, OFF_WD_CONTROL, 32'h1);
    bus(1'b1, OFF_CLOCK_SELECT, 32'h81);
    rdchk(OFF_CLOCK_SELECT, 32'h80);
    SPECIAL_MODE <= 1'b1;
    bus(1'b1, OFF_CLOCK_SELECT, 32'h81);
    rdchk(OFF_CLOCK_SELECT, 32'h81);
    bus(1'b1, OFF_CLOCK_SELECT, 32'h80);
    for (int r = 1; r <= 7; r++) begin
      int p;
      p = 1 << (2 + steps[r - 1]);
      bus(1'b1, OFF_WD_CONTROL, 32'(r));
      ticks(p - 1);
      bus(1'b1, OFF_WD_SERVICE, 32'h55);
      bus(1'b1, OFF_WD_SERVICE, 32'hAA);
      ticks(p - 1);
      check(32'(irst_s), 32'h1);
      ticks(2);
      wait_rst(1'b0, 10);
      wait_rst(1'b1, 1000);
    end
    bus(1'b1, OFF_WD_CONTROL, 32'h1);
    bus(1'b1, OFF_CLOCK_SELECT, 32'hC1);
    ticks(8, 1'b0);
    STOP_MODE <= 1'b1;
    ticks(8, 1'b1);
    check(32'({irst_s, run_s}), 32'h3);
    bus(1'b1, OFF_CLOCK_SELECT, 32'hC5);
    ticks(4, 1'b1);
    wait_rst(1'b0, 10);
    STOP_MODE <= 1'b0;
    wait_rst(1'b1, 1000);
    ticks(20);
    check(32'(irst_s), 32'h1);
    rdchk(OFF_STATUS, 32'h08, 32'h08);
    bus(1'b1, OFF_STATUS, 32'h08);
    rdchk(OFF_STATUS, 32'h00, 32'h08);
    bus(1'b1, OFF_WD_CONTROL, 32'h1);
    bus(1'b1, OFF_WD_SERVICE, 32'h12);
    wait_rst(1'b0, 4);
    wait_rst(1'b1, 1000);
    check(32'(cnt >= 765 && cnt <= 772), 32'h1);
    rdchk(OFF_STATUS, 32'h08, 32'h08);
    EXT_RESET_N <= 1'b0;
    wait_rst(1'b0, 5);
    repeat (900) @(posedge CORE_CLK);
    check(32'(irst_s), 32'h0);
    EXT_RESET_N <= 1'b1;
    wait_rst(1'b1, 5);
    rdchk(OFF_STATUS, 32'h10, 32'h10);
    $display("Watchdog and external reset test done");
    stop_test();
  end

endmodule : tb_top
